// ==== osw_defs.svh ====
// Constants for the octal switch fault and status logic
`ifndef OSW_DEFS_SVH
`define OSW_DEFS_SVH
`define OSW_N         8
`define OSW_ALL_OFF   8'hFF
`define OSW_CLK_NS    10
`define OSW_BLANK_NS  25000
`define OSW_BLANK_CYC ((`OSW_BLANK_NS + `OSW_CLK_NS - 1) / `OSW_CLK_NS)
`define OSW_BLANK_W   12
`endif

// ==== osw_pkg.sv ====
// Types shared by the octal switch fault and status logic
package osw_pkg;
    // Per-output sensor levels and the shared supply level from the analog side
    typedef struct packed {
        logic [7:0] over_temp;
        logic [7:0] drain_low;
        logic       supply_ov;
    } fault_in_t;
endpackage : osw_pkg

// ==== osw_fault_status.sv ====
// Fault detection, output gating and serial status word of the switch
// Contract
// - A low command bit switches its output on, a high bit off.
// - Status shifted out describes the previous command word, not the current.
// - Per-output faults act independently; load supply overvoltage turns all off.
// - Overtemperature turns off only its output; status then reads off.
// - After overtemperature clears, output stays off until next write.
// - Overvoltage keeps all outputs off until cleared and rewritten.
// - First write after overvoltage returns all ones.
// - Open load is judged only on outputs commanded off.
// - Chip select rise starts blanking; comparator ignored until it expires.
// - Open load indication is not latched and clears itself.
// - One comparator: open load when off, short detect when on.
// - A short latches off only the faulted output.
// - Status high for off unfaulted output, low for on unfaulted.
// - Words shift MSB first; MSB is output 7.
// - Chip select rise applies the shifted command to the switches.
// - Open load on an off output returns a low status bit.
`timescale 1ns/100ps
`include "osw_defs.svh"

module osw_fault_status (
    input  wire logic               clk_i,    // System clock
    input  wire logic               rst_i,    // Async reset, high
    input  wire logic               sclk_i,   // Serial link clock
    input  wire logic               cs_n_i,   // Chip select, low
    input  wire logic               si_i,     // Serial command in
    input  wire osw_pkg::fault_in_t fault_i,  // Sensor levels
    output logic                    so_o,     // Serial status out
    output logic                    so_oe_o,  // Status pin enable
    output logic [7:0]              gate_on_o // Output switch drive
);
    import osw_pkg::*;

    // Every check in this block runs on the system clock
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ==========================================================
    // Capture of the status word at chip select fall
    // ==========================================================
    logic [7:0] status_q;
    logic [7:0] cap_q;

    // status_q only moves on clk; a change right at the fall may
    // catch a mixed word, which the next transfer corrects.
    always_ff @(negedge cs_n_i or posedge rst_i) begin
        if (rst_i) begin
            cap_q <= `OSW_ALL_OFF;
        end else begin
            cap_q <= status_q;
        end
    end

    // ==========================================================
    // Link side shifter on the serial clock
    // ==========================================================
    logic [7:0] sr_q;
    logic [7:0] sr_d;
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic       so_q;
    logic       so_d;
    logic       link_rst;

    assign link_rst = rst_i | cs_n_i;

    always_comb begin
        sr_d  = {sr_q[6:0], si_i};
        so_d  = cap_q[3'h7 - cnt_q];
        cnt_d = (cnt_q == 3'h7) ? cnt_q : cnt_q + 3'h1;
    end

    // Shift register is cleared to all off only by reset
    always_ff @(posedge sclk_i or posedge rst_i) begin
        if (rst_i) begin
            sr_q <= `OSW_ALL_OFF;
        end else if (!cs_n_i) begin
            sr_q <= sr_d;
        end
    end

    // Bit position restarts with every frame
    always_ff @(posedge sclk_i or posedge link_rst) begin
        if (link_rst) begin
            cnt_q <= 3'h0;
            so_q  <= 1'b1;
        end else begin
            cnt_q <= cnt_d;
            so_q  <= so_d;
        end
    end

    // ==========================================================
    // Input synchronisers into the clk domain
    // ==========================================================
    fault_in_t  flt_m_q;
    fault_in_t  flt_q;
    logic       cs_m_q;
    logic       cs_s_q;
    logic       cs_p_q;
    logic       cs_rise;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            flt_m_q <= '0;
            flt_q   <= '0;
            cs_m_q  <= 1'b1;
            cs_s_q  <= 1'b1;
            cs_p_q  <= 1'b1;
        end else begin
            flt_m_q <= fault_i;
            flt_q   <= flt_m_q;
            cs_m_q  <= cs_n_i;
            cs_s_q  <= cs_m_q;
            cs_p_q  <= cs_s_q;
        end
    end

    assign cs_rise = cs_s_q & ~cs_p_q;

    // ==========================================================
    // Command, overvoltage and blanking state
    // ==========================================================
    logic [7:0]              cmd_q;
    logic [7:0]              cmd_d;
    logic                    ov_q;
    logic                    ov_d;
    logic [`OSW_BLANK_W-1:0] blank_q;
    logic [`OSW_BLANK_W-1:0] blank_d;
    logic                    blank_done;
    logic                    oe_q;

    assign blank_done = (blank_q == '0);

    always_comb begin
        cmd_d   = cmd_q;
        ov_d    = ov_q;
        blank_d = blank_done ? blank_q : blank_q - `OSW_BLANK_W'(1);
        if (flt_q.supply_ov) begin
            ov_d  = 1'b1;
            cmd_d = `OSW_ALL_OFF;
        end else if (cs_rise) begin
            ov_d  = 1'b0;
            cmd_d = sr_q;
        end
        if (cs_rise) begin
            blank_d = `OSW_BLANK_W'(`OSW_BLANK_CYC - 1);
        end
    end

    // sr_q is quiet once chip select is high, so it is read here
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_q   <= `OSW_ALL_OFF;
            ov_q    <= 1'b0;
            blank_q <= '0;
            oe_q    <= 1'b0;
        end else begin
            cmd_q   <= cmd_d;
            ov_q    <= ov_d;
            blank_q <= blank_d;
            oe_q    <= ~cs_s_q;
        end
    end

    // ==========================================================
    // Per-output fault latches, gate drive and status
    // ==========================================================
    logic [7:0] ot_q;
    logic [7:0] sc_q;
    logic [7:0] gate_q;
    logic [7:0] open_load;

    for (genvar i = 0; i < `OSW_N; i++) begin : g_out
        logic ot_d;
        logic sc_d;
        logic gate_d;
        logic stat_d;

        always_comb begin
            // Overtemperature holds until a write after it cools
            ot_d = flt_q.over_temp[i] | (ot_q[i] & ~cs_rise);
            // Comparator above threshold while on means a short
            sc_d = (gate_q[i] & blank_done & ~flt_q.drain_low[i]
                    & ~cs_rise) | (sc_q[i] & ~cs_rise);
            gate_d = ~cmd_q[i] & ~ot_q[i] & ~flt_q.over_temp[i]
                     & ~sc_q[i] & ~ov_q;
            // Open load only on outputs commanded off, unlatched
            open_load[i] = cmd_q[i] & ~gate_q[i] & blank_done
                           & flt_q.drain_low[i];
            if (ov_q) begin
                stat_d = 1'b1;
            end else if (gate_q[i]) begin
                stat_d = 1'b0;
            end else begin
                stat_d = ~open_load[i];
            end
        end

        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                ot_q[i]     <= 1'b0;
                sc_q[i]     <= 1'b0;
                gate_q[i]   <= 1'b0;
                status_q[i] <= 1'b1;
            end else begin
                ot_q[i]     <= ot_d;
                sc_q[i]     <= sc_d;
                gate_q[i]   <= gate_d;
                status_q[i] <= stat_d;
            end
        end
    end

    assign so_o      = so_q;
    assign so_oe_o   = oe_q;
    assign gate_on_o = gate_q;

    // ==========================================================
    // Assertions on the clk domain
    // ==========================================================
    property p_ov_off;
        flt_q.supply_ov |-> ##2 (gate_q == 8'h00);
    endproperty
    a_ov_off: assert property (p_ov_off)
        else $error("outputs on during overvoltage");

    property p_ov_status;
        ov_q |=> (status_q == `OSW_ALL_OFF);
    endproperty
    a_ov_status: assert property (p_ov_status)
        else $error("status not all ones after overvoltage");

    property p_ot_off;
        flt_q.over_temp[0] && !cmd_q[0] |-> ##1 !gate_q[0] ##1 status_q[0];
    endproperty
    a_ot_off: assert property (p_ot_off)
        else $error("overtemperature output not off");

    property p_ot_hold;
        ot_q[0] && !cs_rise |=> ot_q[0];
    endproperty
    a_ot_hold: assert property (p_ot_hold)
        else $error("overtemperature latch released early");

    property p_apply;
        cs_rise && !flt_q.supply_ov |=> (cmd_q == $past(sr_q));
    endproperty
    a_apply: assert property (p_apply)
        else $error("command not applied at chip select rise");

    property p_blank;
        cs_rise |=> (open_load == 8'h00) [*8];
    endproperty
    a_blank: assert property (p_blank)
        else $error("comparator used during blanking");

    property p_open_low;
        (open_load != 8'h00) && !ov_q |=> ((status_q & $past(open_load)) == 8'h00);
    endproperty
    a_open_low: assert property (p_open_low)
        else $error("open load not reported low");

    property p_on_low;
        gate_q[0] && !ov_q |=> !status_q[0];
    endproperty
    a_on_low: assert property (p_on_low)
        else $error("on output status not low");

    property p_short;
        gate_q[7] && blank_done && !flt_q.drain_low[7] && !cs_rise
            |-> ##2 (!gate_q[7] && (gate_q[6] || !$past(gate_q[6], 2) || ot_q[6]
            || sc_q[6] || ov_q || $past(cs_rise)));
    endproperty
    a_short: assert property (p_short)
        else $error("short did not latch only its output");

    property p_gate_cmd;
        1'b1 |=> ((gate_q & $past(cmd_q)) == 8'h00);
    endproperty
    a_gate_cmd: assert property (p_gate_cmd)
        else $error("output on while commanded off");

    property p_ov_hold;
        ov_q && !cs_rise |=> ov_q && (gate_q == 8'h00);
    endproperty
    a_ov_hold: assert property (p_ov_hold)
        else $error("overvoltage hold released without a write");

    property p_ot_clear;
        ot_q[0] && cs_rise && !flt_q.over_temp[0] |=> !ot_q[0];
    endproperty
    a_ot_clear: assert property (p_ot_clear)
        else $error("cooled output not released by the write");

    c_ov: cover property (ov_q ##1 cs_rise);
    c_ot: cover property (ot_q[0] && !flt_q.over_temp[0]);
    c_open: cover property (open_load != 8'h00);
    c_short: cover property (sc_q[7]);
    c_apply: cover property (cs_rise ##2 (gate_q != 8'h00));
endmodule : osw_fault_status

// ==== osw_host.sv ====
// Host model driving the serial command link of the switch
`timescale 1ns/100ps

module osw_host #(
    parameter int HALF_NS = 24      // Half period of the link clock
) (
    output logic      sclk_o,       // Link clock, low outside frames
    output logic      cs_n_o,       // Chip select, low
    output logic      si_o,         // Command bit
    input  wire logic so_i          // Status bit
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o   = 1'b0;
    end

    // ========================================
    // One write, status sampled on falling link edge
    task automatic xfer(input logic [7:0] cmd, output logic [7:0] st);
        cs_n_o = 1'b0;
        si_o   = cmd[7];
        for (int k = 7; k >= 0; k--) begin
            #(HALF_NS) sclk_o = 1'b1;
            #(HALF_NS) sclk_o = 1'b0;
            st[k] = so_i;
            if (k > 0) begin
                si_o = cmd[k - 1];
            end
        end
        #(HALF_NS) cs_n_o = 1'b1;
    endtask : xfer
endmodule : osw_host

// ==== octal_switch_fault_status_logic_test.sv ====
// Self-checking bench for the switch fault and status logic
`timescale 1ns/100ps

module octal_switch_fault_status_logic_test;
    import osw_pkg::*;
    logic       clk, rst, sclk, cs_n, si, so, so_oe, so_pin, ov;
    logic [7:0] gate_on, hot, open_m, short_m;
    fault_in_t  fault;
    int         n_errors = 0;
    int         checks = 0;

    // Released status line shows the inverse, never a stale bit
    assign so_pin = so_oe ? so : ~so;

    osw_host host (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so_pin));

    osw_fault_status DUT (.clk_i(clk), .rst_i(rst), .sclk_i(sclk), .cs_n_i(cs_n),
        .si_i(si), .fault_i(fault), .so_o(so), .so_oe_o(so_oe), .gate_on_o(gate_on));

    // Drain below threshold when conducting unless shorted, or when open
    always @(negedge clk) begin
        fault.over_temp <= hot;
        fault.drain_low <= (gate_on & ~short_m) | open_m;
        fault.supply_ov <= ov;
    end

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ========================================
    // Helpers
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] cmd, input logic [7:0] exp);
        logic [7:0] st;
        host.xfer(cmd, st);
        chk(st, exp);
    endtask : wr

    task automatic settle();
        repeat (10050) @(negedge clk);
    endtask : settle

    task automatic wait_gate(input logic [7:0] exp);
        int n;
        n = 0;
        while (gate_on !== exp && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk(gate_on, exp);
        if (gate_on !== exp) begin
            complete_run();
        end
    endtask : wait_gate

    // ========================================
    // Scenarios
    task automatic t_basic();
        chk(gate_on, 8'h00);
        chk({7'h00, so_oe}, 8'h00);
        wr(8'hA5, 8'hFF);
        repeat (100) @(negedge clk);
        wr(8'hA5, 8'hA5);
        settle();
        wr(8'h3C, 8'hA5);
        settle();
        chk(gate_on, 8'hC3);
        $display("t_basic done");
    endtask : t_basic

    task automatic t_open();
        open_m = 8'h05;
        settle();
        wr(8'h3C, 8'h38);
        open_m = 8'h00;
        settle();
        wr(8'h3C, 8'h3C);
        $display("t_open done");
    endtask : t_open

    task automatic t_hot();
        settle();
        hot = 8'h01;
        wait_gate(8'hC2);
        hot = 8'h00;
        repeat (20) @(negedge clk);
        chk(gate_on, 8'hC2);
        wr(8'h3C, 8'h3D);
        settle();
        chk(gate_on, 8'hC3);
        $display("t_hot done");
    endtask : t_hot

    task automatic t_short();
        short_m = 8'h80;
        wait_gate(8'h43);
        short_m = 8'h00;
        repeat (20) @(negedge clk);
        chk(gate_on, 8'h43);
        wr(8'h3C, 8'hBC);
        settle();
        chk(gate_on, 8'hC3);
        $display("t_short done");
    endtask : t_short

    task automatic t_ov();
        ov = 1'b1;
        wait_gate(8'h00);
        wr(8'h00, 8'hFF);
        repeat (20) @(negedge clk);
        chk(gate_on, 8'h00);
        ov = 1'b0;
        repeat (20) @(negedge clk);
        chk(gate_on, 8'h00);
        wr(8'h0F, 8'hFF);
        settle();
        chk(gate_on, 8'hF0);
        wr(8'h0F, 8'h0F);
        $display("t_ov done");
    endtask : t_ov

    initial begin
        rst = 1'b1;
        ov = 1'b0;
        hot = 8'h00;
        open_m = 8'h00;
        short_m = 8'h00;
        fault = '0;
        repeat (2) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        repeat (4) @(negedge clk);
        t_basic();
        t_open();
        t_hot();
        t_short();
        t_ov();
        complete_run();
    end

    // Watchdog on the whole run
    initial begin
        #1000000;
        n_errors++;
        complete_run();
    end
endmodule : octal_switch_fault_status_logic_test
